/* core/udcc_map.vh */
// Register map, field positions and mode codes of the up/down capture block
`ifndef UDCC_MAP_VH
`define UDCC_MAP_VH

// Register byte offsets
`define UDCC_CTRL_OFS      8'h00
`define UDCC_COUNT_OFS     8'h04
`define UDCC_STATUS_OFS    8'h08
`define UDCC_CH_BASE       8'h20
`define UDCC_CH_STRIDE     8'h08
`define UDCC_CH_DATA_OFS   8'h04

// Control register fields
`define UDCC_MODE_LSB      0
`define UDCC_CLEAR_BIT     2
`define UDCC_GROUP_LSB     3
`define UDCC_LEN_LSB       5
`define UDCC_DIV_LSB       7

// Status register fields
`define UDCC_OVF_BIT       0

// Channel control fields
`define UDCC_SAMPLE_BIT    0
`define UDCC_EDGE_LSB      1
`define UDCC_ISEL_LSB      3
`define UDCC_SYNC_BIT      5
`define UDCC_LSEL_LSB      6
`define UDCC_LEVEL_BIT     8
`define UDCC_OVR_BIT       9
`define UDCC_FLAG_BIT      10

// Mode control codes
`define UDCC_MODE_STOP     2'h0
`define UDCC_MODE_UP       2'h1
`define UDCC_MODE_CONT     2'h2
`define UDCC_MODE_UPDN     2'h3

// Latch load select codes
`define UDCC_LD_NOW        2'h0
`define UDCC_LD_ZERO       2'h1
`define UDCC_LD_MODE       2'h2
`define UDCC_LD_OLD        2'h3

// Input select codes
`define UDCC_IN_A          2'h0
`define UDCC_IN_B          2'h1
`define UDCC_IN_GND        2'h2
`define UDCC_IN_VCC        2'h3

// Reset values
`define UDCC_CTRL_RST      9'h000
`define UDCC_CHCFG_RST     8'h00

`endif

/* core/udcc_timer.v */
// Up/down timer with capture/compare channels and grouped latches, APB slave
//
// The APB slave port and the register offsets were left to the implementer.
`include "udcc_map.vh"
`default_nettype none

// How it works
// (R1) Up/down counts zero to period and back
// (R2) Period above max count acts continuous
// (R3) Direction kept on stop; clear resets count and direction
// (R4) Channel0 flag at period, overflow at 1->0
// (R5) Period load while down: descend to zero
// (R6) Larger new period: count up to it
// (R7) Period below count: turn down, one extra
// (R8) Three or seven identical channels
// (R9) Capture mode, input/edge select, level readable
// (R10) Capture copies counter, sets channel flag
// (R11) Sync bit delays capture to next clock
// (R12) Second unread capture sets sticky overrun
// (R13) Select bit1 high: input is supply/ground
// (R14) Compare mode: flag and match at latch
// (R15) Latch hidden, loaded from channel register
// (R16) Load on write or at zero
// (R17) Mode load: zero, or old period up/down
// (R18) Load when count hits old latch value
// (R19) Group controller's select sets group event
// (R20) Controller select zero: no grouping, immediate
// (R21) Group loads after all members written
// (R22) Grouping field encodes four settings
// (R23) Load select 00 is immediate
// (R24) Mode codes stop, up, cont, up/down
// (R25) Count events only while counting
// (R26) Load select: now, zero, mode, old latch
// (R27) Channel register reads tracked for overrun
module udcc_timer #(
   parameter NCH = 7                                          // (R8)
) (
   // APB clock and reset
   input  wire              pclk,
   input  wire              presetn,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   // Capture inputs
   input  wire [NCH-1:0]    capture_input_a,
   input  wire [NCH-1:0]    capture_input_b,
   // Compare match pulses to output units
   output reg  [NCH-1:0]    match_signal
);

////////////////////////////////////////////////////////////////////////////
// Bus decode
wire        acc      = psel & penable & pready;
wire        wr_acc   = acc & pwrite;
wire        rd_acc   = acc & ~pwrite;
wire        in_ch    = (paddr >= `UDCC_CH_BASE) &&
                       ({2'h0, paddr} < ({2'h0, `UDCC_CH_BASE} +
                        10'd8 * NCH[9:0]));
wire [7:0]  ch_rel   = paddr - `UDCC_CH_BASE;
wire [4:0]  ch_idx   = ch_rel[7:3];
wire        ch_data  = ch_rel[2];
wire        map_hit  = (paddr == `UDCC_CTRL_OFS) ||
                       (paddr == `UDCC_COUNT_OFS) ||
                       (paddr == `UDCC_STATUS_OFS) ||
                       (in_ch && ch_rel[1:0] == 2'h0);

////////////////////////////////////////////////////////////////////////////
// Global control
reg  [1:0]  mode_reg;
reg  [1:0]  group_reg;
reg  [1:0]  len_reg;
reg  [1:0]  div_reg;
reg  [2:0]  div_cnt_reg;
reg  [15:0] cnt_reg;
reg         dir_reg;
reg         ovf_reg;

wire        ctrl_wr  = wr_acc && paddr == `UDCC_CTRL_OFS;
wire        clear_wr = ctrl_wr && pwdata[`UDCC_CLEAR_BIT];
wire        cnt_wr   = wr_acc && paddr == `UDCC_COUNT_OFS;

wire [15:0] max_cnt  = (len_reg == 2'h0) ? 16'h00ff :
                       (len_reg == 2'h1) ? 16'h03ff :
                       (len_reg == 2'h2) ? 16'h0fff : 16'hffff;
wire [2:0]  div_mask = (div_reg == 2'h0) ? 3'h0 :
                       (div_reg == 2'h1) ? 3'h1 :
                       (div_reg == 2'h2) ? 3'h3 : 3'h7;
wire        tick     = (mode_reg != `UDCC_MODE_STOP) &&
                       ((div_cnt_reg & div_mask) == div_mask);

wire [16*NCH-1:0] latch_flat;
wire [2*NCH-1:0]  lsel_flat;
wire [NCH-1:0]    pend_flat;
wire [15:0]       period = latch_flat[15:0];

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      mode_reg  <= 2'h0;
      group_reg <= 2'h0;
      len_reg   <= 2'h3;
      div_reg   <= 2'h0;
   end else if (ctrl_wr) begin
      mode_reg  <= pwdata[`UDCC_MODE_LSB +: 2];               // (R24)
      group_reg <= pwdata[`UDCC_GROUP_LSB +: 2];
      len_reg   <= pwdata[`UDCC_LEN_LSB +: 2];
      div_reg   <= pwdata[`UDCC_DIV_LSB +: 2];
   end
end

////////////////////////////////////////////////////////////////////////////
// Counter
reg  [15:0] cnt_nx;
reg         dir_nx;
reg         ovf_set;

always @* begin
   cnt_nx  = cnt_reg;
   dir_nx  = dir_reg;
   ovf_set = 1'b0;
   if (tick) begin
      case (mode_reg)
         `UDCC_MODE_UP: begin
            if (cnt_reg >= period) begin
               cnt_nx  = 16'h0000;
               ovf_set = (period != 16'h0000);
            end else begin
               cnt_nx = cnt_reg + 16'h0001;
            end
         end
         `UDCC_MODE_CONT: begin
            if (cnt_reg >= max_cnt) begin
               cnt_nx  = 16'h0000;
               ovf_set = 1'b1;
            end else begin
               cnt_nx = cnt_reg + 16'h0001;
            end
         end
         `UDCC_MODE_UPDN: begin
            if (period > max_cnt) begin                       // (R2)
               if (cnt_reg >= max_cnt) begin
                  cnt_nx  = 16'h0000;
                  ovf_set = 1'b1;
               end else begin
                  cnt_nx = cnt_reg + 16'h0001;
               end
            end else if (dir_reg) begin                       // (R5)
               if (cnt_reg <= 16'h0001) begin
                  cnt_nx  = 16'h0000;
                  dir_nx  = 1'b0;                             // (R1)
                  ovf_set = (cnt_reg == 16'h0001);            // (R4)
               end else begin
                  cnt_nx = cnt_reg - 16'h0001;
               end
            end else if (period == 16'h0000) begin
               cnt_nx = 16'h0000;
            end else if (cnt_reg >= period) begin             // (R6)
               dir_nx = 1'b1;                                 // (R7)
               cnt_nx = cnt_reg - 16'h0001;
            end else begin
               cnt_nx = cnt_reg + 16'h0001;                   // (R1)
            end
         end
         default: cnt_nx = cnt_reg;
      endcase
   end
end

// Count events are gated off by any software write to the counter
wire cnt_evt  = tick && (cnt_nx != cnt_reg) && !cnt_wr && !clear_wr; // (R25)
wire zero_evt = cnt_evt && (cnt_nx == 16'h0000);
wire per_evt  = cnt_evt && (cnt_nx == period);

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      cnt_reg     <= 16'h0000;
      dir_reg     <= 1'b0;
      div_cnt_reg <= 3'h0;
   end else if (clear_wr) begin
      cnt_reg     <= 16'h0000;                                // (R3)
      dir_reg     <= 1'b0;
      div_cnt_reg <= 3'h0;
   end else begin
      if (mode_reg != `UDCC_MODE_STOP)
         div_cnt_reg <= div_cnt_reg + 3'h1;
      if (cnt_wr)
         cnt_reg <= pwdata[15:0] & max_cnt;
      else
         cnt_reg <= cnt_nx;
      dir_reg <= dir_nx;                                      // (R3)
   end
end

// Overflow flag: write 1 clears, hardware set wins
wire ovf_clr = wr_acc && paddr == `UDCC_STATUS_OFS && pwdata[`UDCC_OVF_BIT];

always @(posedge pclk or negedge presetn) begin
   if (!presetn)
      ovf_reg <= 1'b0;
   else if (ovf_set && cnt_evt)
      ovf_reg <= 1'b1;                                        // (R4)
   else if (ovf_clr)
      ovf_reg <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// Grouping
// Controlling channel of channel ch under grouping setting g
function integer ctl_of;                                      // (R22)
   input integer ch;
   input [1:0]   g;
   begin
      case (g)
         2'h1:    ctl_of = (ch == 0) ? 0 : ((ch - 1) / 2) * 2 + 1;
         2'h2:    ctl_of = (ch == 0) ? 0 : (ch <= 3) ? 1 : 4;
         2'h3:    ctl_of = 1;
         default: ctl_of = ch;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// Channels
wire [32*NCH-1:0] rd_flat;
genvar gi;
generate
   for (gi = 0; gi < NCH; gi = gi + 1) begin : ch
      reg  [7:0]  cfg_reg;
      reg  [15:0] data_reg;
      reg  [15:0] latch_reg;
      reg         flag_reg;
      reg         ovr_reg;
      reg         unread_reg;
      reg         pend_reg;
      reg         lvl_reg;
      reg         dly_reg;
      reg         match_reg;
      reg  [1:0]  eff_sel;
      reg         grouped;
      reg         all_wr;
      reg         ld_evt;
      integer     ctl;
      integer     j;

      wire        sel_me  = in_ch && ch_idx == gi;
      wire        cfg_wr  = wr_acc && sel_me && !ch_data;
      wire        dat_wr  = wr_acc && sel_me && ch_data;
      wire        dat_rd  = rd_acc && sel_me && ch_data;
      wire        cap_md  = cfg_reg[`UDCC_SAMPLE_BIT];
      wire [1:0]  edge_s  = cfg_reg[`UDCC_EDGE_LSB +: 2];
      wire [1:0]  isel    = cfg_reg[`UDCC_ISEL_LSB +: 2];

      // (R9) (R13) Input mux, upper select bit gives ground or supply
      wire        in_lvl  = isel[1] ? isel[0] :
                            isel[0] ? capture_input_b[gi] :
                                      capture_input_a[gi];
      wire        edge_hit = cap_md &&
                             ((edge_s[0] && in_lvl && !lvl_reg) ||
                              (edge_s[1] && !in_lvl && lvl_reg));
      wire        cap_now = cfg_reg[`UDCC_SYNC_BIT] ? dly_reg : edge_hit;
      wire        cmp_hit = !cap_md && cnt_evt && cnt_nx == latch_reg;

      always @* begin
         ctl     = ctl_of(gi, group_reg);
         grouped = 1'b0;
         all_wr  = 1'b1;
         for (j = 0; j < NCH; j = j + 1) begin
            if (ctl_of(j, group_reg) == ctl) begin
               all_wr = all_wr & pend_flat[j];                // (R21)
               if (j != gi)
                  grouped = 1'b1;
            end
         end
         if (ctl >= NCH)
            ctl = gi;
         // (R19) (R20) Controller select zero drops grouping
         if (group_reg != 2'h0 && grouped &&
             lsel_flat[2*ctl +: 2] != `UDCC_LD_NOW) begin
            eff_sel = lsel_flat[2*ctl +: 2];
         end else begin
            eff_sel = (group_reg != 2'h0 && grouped) ? `UDCC_LD_NOW :
                      cfg_reg[`UDCC_LSEL_LSB +: 2];
            grouped = 1'b0;
            all_wr  = pend_reg;
         end
         case (eff_sel)                                       // (R26)
            `UDCC_LD_ZERO: ld_evt = zero_evt;                 // (R16)
            `UDCC_LD_MODE: ld_evt = zero_evt ||               // (R17)
                              (mode_reg == `UDCC_MODE_UPDN && per_evt);
            `UDCC_LD_OLD:  ld_evt = cnt_evt &&                // (R18)
                              cnt_nx == latch_reg;
            default:       ld_evt = 1'b0;
         endcase
      end

      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg_reg    <= `UDCC_CHCFG_RST;
            data_reg   <= 16'h0000;
            latch_reg  <= 16'h0000;
            flag_reg   <= 1'b0;
            ovr_reg    <= 1'b0;
            unread_reg <= 1'b0;
            pend_reg   <= 1'b0;
            lvl_reg    <= 1'b0;
            dly_reg    <= 1'b0;
            match_reg  <= 1'b0;
         end else begin
            lvl_reg   <= in_lvl;
            dly_reg   <= edge_hit;                            // (R11)
            match_reg <= cmp_hit;                             // (R14)
            if (cfg_wr)
               cfg_reg <= pwdata[7:0];
            // Flags: hardware set wins over write-1 clear
            if (cmp_hit || cap_now)
               flag_reg <= 1'b1;                              // (R10)
            else if (cfg_wr && pwdata[`UDCC_FLAG_BIT])
               flag_reg <= 1'b0;
            if (cap_now && unread_reg)
               ovr_reg <= 1'b1;                               // (R12)
            else if (cfg_wr && pwdata[`UDCC_OVR_BIT])
               ovr_reg <= 1'b0;
            if (cap_now)
               unread_reg <= 1'b1;
            else if (dat_rd)
               unread_reg <= 1'b0;                            // (R27)
            if (cap_now)
               data_reg <= cnt_reg;                           // (R10)
            else if (dat_wr)
               data_reg <= pwdata[15:0];
            // (R15) (R23) Latch only reachable through the data register
            if (dat_wr && eff_sel == `UDCC_LD_NOW) begin
               latch_reg <= pwdata[15:0];
               pend_reg  <= 1'b0;
            end else if (ld_evt && all_wr) begin
               latch_reg <= data_reg;                         // (R21)
               pend_reg  <= dat_wr;
            end else if (dat_wr) begin
               pend_reg  <= 1'b1;
            end
         end
      end

      assign latch_flat[16*gi +: 16] = latch_reg;
      assign lsel_flat[2*gi +: 2]    = cfg_reg[`UDCC_LSEL_LSB +: 2];
      assign pend_flat[gi]           = pend_reg;
      assign rd_flat[32*gi +: 32]    = ch_data ? {16'h0000, data_reg} :
                                       {21'h000000, flag_reg, ovr_reg,
                                        in_lvl, cfg_reg};      // (R9)

      always @(posedge pclk or negedge presetn) begin
         if (!presetn)
            match_signal[gi] <= 1'b0;
         else
            match_signal[gi] <= match_reg;
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////////
// APB answer, one wait-free access phase
reg [31:0] rd_mux;
integer    k;
always @* begin
   rd_mux = 32'h00000000;
   if (paddr == `UDCC_CTRL_OFS)
      rd_mux = {23'h000000, div_reg, len_reg, group_reg, 1'b0, mode_reg};
   else if (paddr == `UDCC_COUNT_OFS)
      rd_mux = {16'h0000, cnt_reg};
   else if (paddr == `UDCC_STATUS_OFS)
      rd_mux = {30'h00000000, dir_reg, ovf_reg};
   else if (in_ch)
      for (k = 0; k < NCH; k = k + 1)
         if (ch_idx == k)
            rd_mux = rd_flat[32*k +: 32];
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
   end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !map_hit;
      prdata  <= (pwrite || !map_hit) ? 32'h00000000 : rd_mux;
   end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
   end
end

endmodule

`default_nettype wire

/* tb/tb_updown_capture_compare_latch.sv */
// Self-checking bench for the up/down capture/compare timer
`default_nettype none
`include "udcc_map.vh"
module tb_updown_capture_compare_latch;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NCH = 7;
   logic           pclk = 1'b0;
   logic           presetn = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic [NCH-1:0] cap_a;
   logic [NCH-1:0] cap_b;
   logic [NCH-1:0] match_signal;
   logic [31:0]    rd;
   logic           err;
   int             failures = 0;
   int             comparisons = 0;
   int             cycles = 0;
   int             m1 = 0;
   int             mk;

   always #2.5 pclk = ~pclk;

   udcc_timer #(.NCH(NCH)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .capture_input_a(cap_a),
      .capture_input_b(cap_b), .match_signal(match_signal)
   );
   udcc_cap_src #(.NCH(NCH)) SRC (
      .pclk(pclk), .capture_input_a(cap_a), .capture_input_b(cap_b)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64)
         failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Up/down run with grouping 01, then stop
   task automatic run_updn;
      apb(1'b1, `UDCC_CTRL_OFS, 32'h6b);
      repeat (20) @(posedge pclk);
      apb(1'b1, `UDCC_CTRL_OFS, 32'h68);
   endtask

   function automatic logic [7:0] cfg(input int i);
      return 8'(`UDCC_CH_BASE + `UDCC_CH_STRIDE * i);
   endfunction

   function automatic logic [7:0] dat(input int i);
      return 8'(cfg(i) + `UDCC_CH_DATA_OFS);
   endfunction

   always @(posedge pclk) begin
      cycles++;
      if (match_signal[1] === 1'b1)
         m1++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `UDCC_COUNT_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, cfg(1), 32'h0);
      chk(rd, 32'h0);
      // Up/down, period 4, channel 1 compares at 3
      apb(1'b1, dat(0), 32'h4);
      apb(1'b1, dat(1), 32'h3);
      apb(1'b1, `UDCC_CTRL_OFS, 32'h63);
      // Each call takes three edges; count is a triangle of period 8
      for (int i = 0; i < 12; i++) begin
         int t;
         t = (1 + 3 * i) % 8;
         apb(1'b0, `UDCC_COUNT_OFS, 32'h0);
         chk(rd, 32'(t <= 4 ? t : 8 - t));
      end
      apb(1'b1, `UDCC_CTRL_OFS, 32'h60);
      apb(1'b0, `UDCC_STATUS_OFS, 32'h0);
      chk(rd & 32'h1, 32'h1);
      chk(rd & 32'h2, 32'h2);
      apb(1'b0, cfg(0), 32'h0);
      chk(rd & 32'h400, 32'h400);
      apb(1'b0, cfg(1), 32'h0);
      chk(rd & 32'h400, 32'h400);
      chk(32'(m1 > 1), 32'h1);
      // Clear resets counter and direction
      apb(1'b1, `UDCC_CTRL_OFS, 32'h64);
      apb(1'b0, `UDCC_COUNT_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `UDCC_STATUS_OFS, 32'h1);
      apb(1'b0, `UDCC_STATUS_OFS, 32'h0);
      chk(rd, 32'h0);
      // Writing the counter to the compare value directly fires nothing
      apb(1'b1, cfg(1), 32'h400);
      mk = m1;
      apb(1'b1, `UDCC_COUNT_OFS, 32'h3);
      repeat (4) @(posedge pclk);
      apb(1'b0, cfg(1), 32'h0);
      chk(rd, 32'h0);
      chk(32'(m1 - mk), 32'h0);
      // Capture on input A rising, synchronised, then overrun
      apb(1'b1, cfg(3), 32'h23);
      apb(1'b1, `UDCC_COUNT_OFS, 32'h55);
      SRC.drive(1'b0, 3, 1'b1);
      repeat (3) @(posedge pclk);
      apb(1'b0, cfg(3), 32'h0);
      chk(rd, 32'h523);
      SRC.drive(1'b0, 3, 1'b0);
      apb(1'b1, `UDCC_COUNT_OFS, 32'h66);
      SRC.drive(1'b0, 3, 1'b1);
      repeat (3) @(posedge pclk);
      apb(1'b0, cfg(3), 32'h0);
      chk(rd, 32'h723);
      apb(1'b0, dat(3), 32'h0);
      chk(rd, 32'h66);
      apb(1'b0, cfg(3), 32'h0);
      chk(rd, 32'h723);
      apb(1'b1, cfg(3), 32'h623);
      apb(1'b0, cfg(3), 32'h0);
      chk(rd, 32'h123);
      // Capture on input B
      apb(1'b1, cfg(5), 32'h2b);
      SRC.drive(1'b1, 5, 1'b1);
      repeat (3) @(posedge pclk);
      apb(1'b0, cfg(5), 32'h0);
      chk(rd, 32'h52b);
      // Software capture by switching ground to supply
      apb(1'b1, `UDCC_COUNT_OFS, 32'h12);
      apb(1'b1, cfg(4), 32'h37);
      apb(1'b1, cfg(4), 32'h3f);
      repeat (3) @(posedge pclk);
      apb(1'b0, dat(4), 32'h0);
      chk(rd, 32'h12);
      apb(1'b0, cfg(4), 32'h0);
      chk(rd, 32'h53f);
      // Pair 1+2 loads at zero only once both registers are written
      apb(1'b1, `UDCC_CTRL_OFS, 32'h6c);
      apb(1'b1, cfg(1), 32'h440);
      apb(1'b1, dat(1), 32'h7);
      for (int ph = 0; ph < 2; ph++) begin
         if (ph == 1)
            apb(1'b1, dat(2), 32'h7);
         run_updn();
         apb(1'b1, cfg(1), 32'h440);
         apb(1'b1, cfg(2), 32'h400);
         run_updn();
         apb(1'b0, cfg(1), 32'h0);
         chk(rd, ph == 0 ? 32'h440 : 32'h40);
         apb(1'b0, cfg(2), 32'h0);
         chk(rd, ph == 0 ? 32'h400 : 32'h0);
      end
      // Period above the 8-bit maximum runs on like continuous
      apb(1'b1, dat(0), 32'h100);
      apb(1'b1, `UDCC_CTRL_OFS, 32'h07);
      apb(1'b1, `UDCC_STATUS_OFS, 32'h1);
      apb(1'b1, `UDCC_COUNT_OFS, 32'hfc);
      apb(1'b0, `UDCC_STATUS_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `UDCC_COUNT_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `UDCC_STATUS_OFS, 32'h0);
      chk(rd, 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire

/* tb/udcc_cap_src.sv */
// Capture source model driving the timer's capture inputs
`default_nettype none
module udcc_cap_src #(
   parameter int NCH = 7
) (
   // Clock
   input  wire logic           pclk,
   // Capture levels
   output var  logic [NCH-1:0] capture_input_a,
   output var  logic [NCH-1:0] capture_input_b
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      capture_input_a = '0;
      capture_input_b = '0;
   end
   // Levels change just after a clock edge, synchronous to the timer
   task automatic drive(input bit use_b, input int ch, input logic v);
      @(posedge pclk);
      if (use_b)
         capture_input_b[ch] <= v;
      else
         capture_input_a[ch] <= v;
   endtask
endmodule
`default_nettype wire

/* tb/udcc_timer_checker.sv */
// Bus timing and match pulse checker bound to the timer top
`default_nettype none
`include "udcc_map.vh"
module udcc_timer_checker #(
   parameter int NCH = 7
) (
   // Clock and reset
   input wire logic           pclk,
   input wire logic           presetn,
   // Bus
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [7:0]     paddr,
   input wire logic [31:0]    pwdata,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   // Capture and match
   input wire logic [NCH-1:0] capture_input_a,
   input wire logic [NCH-1:0] capture_input_b,
   input wire logic [NCH-1:0] match_signal
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic setup = psel && !penable;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (setup |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_cause: assert property (pready |-> $past(setup))
      else $error("pready without setup");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_rdata_zero: assert property (pslverr |-> prdata == 32'h0)
      else $error("refused access returned data");
   a_write_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("write returned data");
   a_unmapped_err: assert property (setup && paddr == 8'h0c |=> pslverr)
      else $error("unmapped address not refused");
   a_ctrl_no_err: assert property
      (setup && paddr == `UDCC_CTRL_OFS |=> !pslverr)
      else $error("control access refused");
   a_match_pulse: assert property
      ((match_signal & $past(match_signal)) == '0)
      else $error("match longer than one cycle");
endmodule

bind udcc_timer udcc_timer_checker #(.NCH(NCH)) CHK (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .capture_input_a(capture_input_a),
   .capture_input_b(capture_input_b), .match_signal(match_signal)
);
`default_nettype wire
